// ---- pkg/spc_pkg.sv ----
/*
  Constants for the serial port control block: register offsets, field
  positions, reset values and the clock select codes.
  Assumes a 32-bit classic Wishbone bus with byte addresses.
*/
package spc_pkg;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_MASK = 8'h08;
  localparam logic [7:0] OFS_PINS = 8'h0C;

  // Control register fields
  localparam int B_TX_END_IE = 7;
  localparam int B_RX_IE = 6;
  localparam int B_TX_EN = 5;
  localparam int B_RX_EN = 4;
  localparam int B_MP_IE = 3;
  localparam int B_SYNC_MODE = 2;
  localparam int B_CLOCK_SELECT_HI = 1;
  localparam int B_CLOCK_SELECT_LO = 0;

  // Status and mask fields
  localparam int B_RECEIVE_FULL = 0;
  localparam int B_FRAMING_ERROR = 1;
  localparam int B_OVERRUN_ERROR = 2;
  localparam int B_TX_END = 3;
  localparam int B_MP_WAKE = 4;
  localparam int STATUS_W = 5;

  // Pin register fields
  localparam int B_PIN_SCK = 0;
  localparam int B_PIN_RXD = 1;
  localparam int B_PIN_CLK_EXT = 2;
  localparam int B_PIN_SCK_OE = 3;

  // Clock select codes {hi, lo}
  localparam logic [1:0] CS_INTERNAL = 2'h0;
  localparam logic [1:0] CS_INT_OUT = 2'h1;
  localparam logic [1:0] CS_EXTERNAL = 2'h2;
  localparam logic [1:0] CS_RESERVED = 2'h3;

  // Values after reset
  localparam logic [7:0] RST_CTRL = 8'h00;
  localparam logic [STATUS_W-1:0] RST_STATUS = 5'h00;
  localparam logic [STATUS_W-1:0] RST_MASK = 5'h00;
  localparam logic [31:0] RD_ZERO = 32'h0000_0000;

  // Synchroniser depth on pin inputs, in clock cycles
  localparam int SYNC_STAGES = 2;

endpackage

// ---- src/spc_pin_sync.sv ----
/*
  Two flip-flop synchroniser for a group of pin inputs.
  Assumes the inputs are asynchronous to clk_sys_i; first stage is read
  by the second stage only.
*/
`timescale 1ns/10ps
module spc_pin_sync
  import spc_pkg::*;
#(
  parameter int WIDTH = 2
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic [WIDTH-1:0] pin_i,
  output logic [WIDTH-1:0] sync_o
);

  if (WIDTH < 1) begin : g_chk
    $error("spc_pin_sync: WIDTH must be at least 1");
  end

  typedef struct packed {
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
  } spc_sync_t;

  spc_sync_t cur;
  spc_sync_t next_cur;

  always_comb begin
    next_cur = cur;
    next_cur.stage1 = pin_i;
    next_cur.stage2 = cur.stage1;
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  assign sync_o = cur.stage2;

endmodule // spc_pin_sync

// ---- src/spc_serial_port_control.sv ----
/*
  Serial port control: clock source and clock pin selection, transmit and
  receive enables with pin hand-over, interrupt request gating and the
  multiprocessor wake-up filter, behind a classic Wishbone slave.
  Assumes the shift datapath and baud generator run on clk_sys_i and give
  one-cycle event pulses; rxd and sck pins are asynchronous.
*/
`timescale 1ns/10ps

module spc_serial_port_control
  import spc_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADDR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Serial unit side
  input wire logic baud_clk_i,
  input wire logic tx_data_i,
  input wire logic tx_end_i,
  input wire logic rx_frame_done_i,
  input wire logic rx_mp_bit_i,
  input wire logic rx_framing_err_i,
  input wire logic rx_overrun_i,
  output logic ser_clk_o,
  output logic clk_src_ext_o,
  output logic rx_data_o,
  output logic rx_enable_o,
  output logic tx_enable_o,
  // General purpose port side
  input wire logic gpio_txd_out_i,
  input wire logic gpio_txd_oe_i,
  input wire logic gpio_sck_out_i,
  input wire logic gpio_sck_oe_i,
  output logic gpio_rxd_in_o,
  output logic gpio_sck_in_o,
  // Pins
  input wire logic rxd_pin_i,
  input wire logic sck_pin_i,
  output logic txd_o,
  output logic txd_oe_o,
  output logic sck_o,
  output logic sck_oe_o,
  // Interrupts
  output logic transmit_end_irq_o,
  output logic receive_full_irq_o,
  output logic receive_error_irq_o,
  output logic irq_o
);

  if (ADDR_W < 4 || ADDR_W > 32) begin : g_chk
    $error("spc_serial_port_control: ADDR_W must be 4 to 32");
  end

  typedef struct packed {
    logic [7:0] ctrl;
    logic [STATUS_W-1:0] status;
    logic [STATUS_W-1:0] mask;
    logic ack;
    logic [7:0] rdata;
    logic ser_clk;
    logic clk_ext;
    logic sck_out;
    logic sck_oe;
    logic txd;
    logic txd_oe;
    logic rx_data;
    logic rx_en;
    logic tx_en;
    logic transmit_end_irq;
    logic receive_full_irq;
    logic receive_error_irq;
    logic irq;
  } spc_state_t;

  spc_state_t cur;
  spc_state_t next_cur;

  logic [1:0] pin_sync;
  logic rxd_s;
  logic sck_s;

  spc_pin_sync #(
    .WIDTH(2)
  ) u_sync (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .pin_i({sck_pin_i, rxd_pin_i}),
    .sync_o(pin_sync)
  );

  assign rxd_s = pin_sync[0];
  assign sck_s = pin_sync[1];

  logic [1:0] clk_sel;
  logic sync_mode;
  logic req;
  logic commit_wr;
  logic frame_ok;
  logic mp_wake;
  logic [STATUS_W-1:0] set_bits;
  logic [STATUS_W-1:0] clr_bits;
  logic [7:0] rd_mux;

  assign clk_sel = {cur.ctrl[B_CLOCK_SELECT_HI], cur.ctrl[B_CLOCK_SELECT_LO]};
  assign sync_mode = cur.ctrl[B_SYNC_MODE];
  assign req = wb_cyc_i && wb_stb_i;
  // Writes land only on the edge where the master sees ack
  assign commit_wr = req && cur.ack && wb_we_i && wb_sel_i[0];
  // Wake-up filter: while enabled only addressed frames pass
  assign frame_ok = rx_frame_done_i && cur.ctrl[B_RX_EN]
                    && (!cur.ctrl[B_MP_IE] || rx_mp_bit_i);
  assign mp_wake = rx_frame_done_i && cur.ctrl[B_RX_EN]
                   && cur.ctrl[B_MP_IE] && rx_mp_bit_i;

  always_comb begin
    set_bits = '0;
    set_bits[B_RECEIVE_FULL] = frame_ok;
    set_bits[B_FRAMING_ERROR] = frame_ok && rx_framing_err_i;
    set_bits[B_OVERRUN_ERROR] = frame_ok && rx_overrun_i;
    set_bits[B_TX_END] = tx_end_i && cur.ctrl[B_TX_EN];
    set_bits[B_MP_WAKE] = mp_wake;
    clr_bits = '0;
    if (commit_wr && wb_adr_i == ADDR_W'(OFS_STATUS)) begin
      clr_bits = wb_dat_i[STATUS_W-1:0];
    end
  end

  always_comb begin
    rd_mux = 8'h00;
    unique case (wb_adr_i)
      ADDR_W'(OFS_CTRL): rd_mux = cur.ctrl;
      ADDR_W'(OFS_STATUS): rd_mux = {3'h0, cur.status};
      ADDR_W'(OFS_MASK): rd_mux = {3'h0, cur.mask};
      ADDR_W'(OFS_PINS): rd_mux = {4'h0, cur.sck_oe, cur.clk_ext, rxd_s, sck_s};
      default: rd_mux = 8'h00;
    endcase
  end

  always_comb begin
    next_cur = cur;
    // Bus answer one cycle after the request, dropped the cycle after
    next_cur.ack = req && !cur.ack;
    next_cur.rdata = rd_mux;

    if (commit_wr && wb_adr_i == ADDR_W'(OFS_CTRL)) begin
      next_cur.ctrl = wb_dat_i[7:0];
    end
    if (commit_wr && wb_adr_i == ADDR_W'(OFS_MASK)) begin
      next_cur.mask = wb_dat_i[STATUS_W-1:0];
    end
    // Hardware clear beats a same-cycle software write
    if (mp_wake) begin
      next_cur.ctrl[B_MP_IE] = 1'b0;
    end
    // Set wins over write-one-to-clear
    next_cur.status = (cur.status & ~clr_bits) | set_bits;

    // Clock source and clock pin function
    unique case (clk_sel)
      CS_INTERNAL: begin
        next_cur.clk_ext = 1'b0;
        if (sync_mode) begin
          next_cur.sck_out = baud_clk_i;
          next_cur.sck_oe = 1'b1;
        end else begin
          next_cur.sck_out = gpio_sck_out_i;
          next_cur.sck_oe = gpio_sck_oe_i;
        end
      end
      CS_INT_OUT: begin
        next_cur.clk_ext = 1'b0;
        next_cur.sck_out = baud_clk_i;
        next_cur.sck_oe = 1'b1;
      end
      CS_EXTERNAL: begin
        next_cur.clk_ext = 1'b1;
        next_cur.sck_out = 1'b0;
        next_cur.sck_oe = 1'b0;
      end
      CS_RESERVED: begin
        // Pin released so a bad code cannot fight an outside driver
        next_cur.clk_ext = 1'b1;
        next_cur.sck_out = 1'b0;
        next_cur.sck_oe = 1'b0;
      end
    endcase
    next_cur.ser_clk = next_cur.clk_ext ? sck_s : baud_clk_i;

    // Transmit pin hand-over
    next_cur.tx_en = cur.ctrl[B_TX_EN];
    if (cur.ctrl[B_TX_EN]) begin
      next_cur.txd = tx_data_i;
      next_cur.txd_oe = 1'b1;
    end else begin
      next_cur.txd = gpio_txd_out_i;
      next_cur.txd_oe = gpio_txd_oe_i;
    end

    // Receiver sees idle mark while the pin belongs to GPIO
    next_cur.rx_en = cur.ctrl[B_RX_EN];
    next_cur.rx_data = cur.ctrl[B_RX_EN] ? rxd_s : 1'b1;

    // Interrupt requests
    next_cur.transmit_end_irq = cur.ctrl[B_TX_END_IE] && next_cur.status[B_TX_END];
    next_cur.receive_full_irq = cur.ctrl[B_RX_IE] && !cur.ctrl[B_MP_IE]
                   && next_cur.status[B_RECEIVE_FULL];
    next_cur.receive_error_irq = cur.ctrl[B_RX_IE] && !cur.ctrl[B_MP_IE]
                   && (next_cur.status[B_FRAMING_ERROR]
                       || next_cur.status[B_OVERRUN_ERROR]);
    next_cur.irq = |(next_cur.status & cur.mask);
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      cur <= '0;
      cur.ctrl <= RST_CTRL;
      cur.status <= RST_STATUS;
      cur.mask <= RST_MASK;
      cur.rx_data <= 1'b1;
    end else begin
      cur <= next_cur;
    end
  end

  assign wb_ack_o = cur.ack;
  assign wb_dat_o = RD_ZERO | {24'h00_0000, cur.rdata};
  assign ser_clk_o = cur.ser_clk;
  assign clk_src_ext_o = cur.clk_ext;
  assign rx_data_o = cur.rx_data;
  assign rx_enable_o = cur.rx_en;
  assign tx_enable_o = cur.tx_en;
  assign gpio_rxd_in_o = rxd_s;
  assign gpio_sck_in_o = sck_s;
  assign txd_o = cur.txd;
  assign txd_oe_o = cur.txd_oe;
  assign sck_o = cur.sck_out;
  assign sck_oe_o = cur.sck_oe;
  assign transmit_end_irq_o = cur.transmit_end_irq;
  assign receive_full_irq_o = cur.receive_full_irq;
  assign receive_error_irq_o = cur.receive_error_irq;
  assign irq_o = cur.irq;

  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (rst_i);

  sequence s_mp_wake;
    rx_frame_done_i && rx_mp_bit_i && cur.ctrl[B_RX_EN] && cur.ctrl[B_MP_IE];
  endsequence

  sequence s_mp_filtered;
    rx_frame_done_i && !rx_mp_bit_i && cur.ctrl[B_MP_IE]
    && !cur.status[B_RECEIVE_FULL];
  endsequence

  // Error flags must stay clear too, not only the full flag
  sequence s_mp_err_filtered;
    rx_frame_done_i && !rx_mp_bit_i && cur.ctrl[B_MP_IE]
    && !cur.status[B_FRAMING_ERROR] && !cur.status[B_OVERRUN_ERROR];
  endsequence

  a_async_gpio_sck: assert property (
    (!sync_mode && clk_sel == CS_INTERNAL) |=>
      (sck_oe_o == $past(gpio_sck_oe_i)) && (sck_o == $past(gpio_sck_out_i))
      && !clk_src_ext_o)
    else $error("async internal clock did not leave clock pin to GPIO");

  a_sync_clk_out: assert property (
    (sync_mode && clk_sel == CS_INTERNAL) |=>
      sck_oe_o && !clk_src_ext_o && (sck_o == $past(baud_clk_i)))
    else $error("sync internal clock not driven on clock pin");

  a_async_clk_out: assert property (
    (!sync_mode && clk_sel == CS_INT_OUT) |=>
      sck_oe_o && !clk_src_ext_o && (ser_clk_o == $past(baud_clk_i)))
    else $error("async code 01 not driving internal clock out");

  a_ext_clk_in: assert property (
    (clk_sel == CS_EXTERNAL) |=> !sck_oe_o && clk_src_ext_o
      && (ser_clk_o == $past(sck_s)))
    else $error("external clock code did not select clock pin input");

  a_tx_end_gate: assert property (
    !cur.ctrl[B_TX_END_IE] |=> !transmit_end_irq_o)
    else $error("transmit end request raised while disabled");

  a_mp_auto_clear: assert property (
    s_mp_wake |=> !cur.ctrl[B_MP_IE] && cur.status[B_MP_WAKE])
    else $error("addressed frame did not clear multiprocessor enable");

  a_mp_flag_block: assert property (
    s_mp_filtered |=> !cur.status[B_RECEIVE_FULL] && !receive_full_irq_o
      && !receive_error_irq_o)
    else $error("receive full set during multiprocessor filtering");

  a_rx_disable: assert property (
    !cur.ctrl[B_RX_EN] |=> !rx_enable_o && rx_data_o)
    else $error("receiver not disabled with receive enable low");

  a_tx_pin_owner: assert property (
    cur.ctrl[B_TX_EN] |=> txd_oe_o && tx_enable_o && (txd_o == $past(tx_data_i)))
    else $error("transmit pin not given to transmit data");

  a_rx_irq_gate: assert property (
    (receive_full_irq_o || receive_error_irq_o) |->
      $past(cur.ctrl[B_RX_IE]) && !$past(cur.ctrl[B_MP_IE]))
    else $error("receive request issued without its enable");

  a_mp_err_block: assert property (
    s_mp_err_filtered |=> !cur.status[B_FRAMING_ERROR]
      && !cur.status[B_OVERRUN_ERROR])
    else $error("error flag set during multiprocessor filtering");

  a_rx_off_flags: assert property (
    (!cur.ctrl[B_RX_EN] && !cur.status[B_RECEIVE_FULL]) |=>
      !cur.status[B_RECEIVE_FULL])
    else $error("receive full set while receiver disabled");

  a_rx_pin_serial: assert property (
    cur.ctrl[B_RX_EN] |=> rx_enable_o && (rx_data_o == $past(rxd_s)))
    else $error("receive pin not handed to receiver");

  a_tx_end_raise: assert property (
    (cur.ctrl[B_TX_END_IE] && cur.ctrl[B_TX_EN] && tx_end_i) |=>
      transmit_end_irq_o)
    else $error("transmit end request missing while enabled");

  a_rx_full_raise: assert property (
    (cur.ctrl[B_RX_IE] && !cur.ctrl[B_MP_IE] && cur.ctrl[B_RX_EN]
      && rx_frame_done_i) |=> receive_full_irq_o)
    else $error("receive full request missing while enabled");

endmodule // spc_serial_port_control

// ---- testbench/spc_remote_node.sv ----
/*
  Remote serial node on the pins: an external serial clock and a receive line.
  Assumes the bench says when the clock runs and what level the line carries.
*/
`timescale 1ns/10ps
module spc_remote_node (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic clk_run_i,
  input wire logic rxd_level_i,
  output logic sck_pin_o,
  output logic rxd_pin_o
);
  logic [1:0] div;
  // Clock stands still high between frames
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      div <= 2'h0;
      sck_pin_o <= 1'b1;
    end else if (clk_run_i) begin
      div <= div + 2'h1;
      if (div == 2'h3) begin
        sck_pin_o <= ~sck_pin_o;
      end
    end else begin
      sck_pin_o <= 1'b1;
    end
  end
  assign rxd_pin_o = rxd_level_i;
endmodule // spc_remote_node

// ---- testbench/test_serial_port_control.sv ----
/*
  Self-checking bench for the serial port control block over Wishbone.
  Assumes one clock, registered ack one cycle after the request is taken.
*/
`timescale 1ns/10ps
module test_serial_port_control;
  import spc_pkg::*;
  logic clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, ack;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0000_0000, rdat, q;
  logic baud = 1'b0, txdat = 1'b0, tx_end = 1'b0, frame = 1'b0, mp = 1'b0;
  logic fe = 1'b0, ov = 1'b0, gtx = 1'b1, gtx_oe = 1'b0, gsck = 1'b0, gsck_oe = 1'b1;
  logic run = 1'b0, rxd_lvl = 1'b0, sck_pin, rxd_pin, g_sck;
  logic [2:0] sck_d;
  logic ser_clk, ext, rx_data, rx_en, tx_en, g_rxd, txd, txd_oe, sck, sck_oe;
  logic transmit_end_irq, receive_full_irq, receive_error_irq, irq;
  int fails = 0, compares = 0;
  logic [7:0] codes [4] = '{8'h00, 8'h04, 8'h01, 8'h02};
  logic [3:0] exp_ck [4] = '{4'b0101, 4'b1101, 4'b1101, 4'b0011};

  always #4 clk = ~clk;

  // Pin delayed by the two sync stages and the output register
  always @(posedge clk) sck_d <= {sck_d[1:0], sck_pin};

  spc_serial_port_control i_spc_serial_port_control (.clk_sys_i(clk), .rst_i(rst),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .baud_clk_i(baud),
    .tx_data_i(txdat), .tx_end_i(tx_end), .rx_frame_done_i(frame), .rx_mp_bit_i(mp),
    .rx_framing_err_i(fe), .rx_overrun_i(ov), .ser_clk_o(ser_clk), .clk_src_ext_o(ext),
    .rx_data_o(rx_data), .rx_enable_o(rx_en), .tx_enable_o(tx_en),
    .gpio_txd_out_i(gtx), .gpio_txd_oe_i(gtx_oe), .gpio_sck_out_i(gsck),
    .gpio_sck_oe_i(gsck_oe), .gpio_rxd_in_o(g_rxd), .gpio_sck_in_o(g_sck),
    .rxd_pin_i(rxd_pin), .sck_pin_i(sck_pin), .txd_o(txd), .txd_oe_o(txd_oe),
    .sck_o(sck), .sck_oe_o(sck_oe), .transmit_end_irq_o(transmit_end_irq),
    .receive_full_irq_o(receive_full_irq), .receive_error_irq_o(receive_error_irq), .irq_o(irq));

  spc_remote_node i_spc_remote_node (.clk_sys_i(clk), .rst_i(rst), .clk_run_i(run),
    .rxd_level_i(rxd_lvl), .sck_pin_o(sck_pin), .rxd_pin_o(rxd_pin));

  task automatic close_out;
    if (fails == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // Single classic cycle; waits for ack however long it takes
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'hF;
    wdat <= d;
    do @(posedge clk); while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  task automatic ctrl(input logic [7:0] v);
    wb(1'b1, OFS_CTRL, {24'h00_0000, v});
    repeat (3) @(posedge clk);
  endtask

  // One-cycle event pulse: {tx_end, frame, mp, fe, ov}
  task automatic ev(input logic [4:0] v);
    @(posedge clk);
    {tx_end, frame, mp, fe, ov} <= v;
    @(posedge clk);
    {tx_end, frame, mp, fe, ov} <= 5'h00;
    repeat (2) @(posedge clk);
  endtask

  initial begin
    repeat (5000) @(posedge clk);
    fails++;
    close_out();
  end

  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    wb(1'b0, OFS_CTRL, 32'h0000_0000);
    chk(q, 32'h0000_0000, "ctrl after reset");
    chk(rx_data, 1'b1, "rx idle after reset");
    // Reserved code 11 is never written
    for (int i = 0; i < 4; i++) begin
      baud <= (i != 3);
      ctrl(codes[i]);
      chk({sck, sck_oe, ext, ser_clk}, exp_ck[i], "clock select");
    end
    run <= 1'b1;
    repeat (40) begin
      @(posedge clk);
      chk(ser_clk, sck_d[2], "ext clock follows pin");
      chk(g_sck, sck_d[1], "clock pin to port input");
    end
    run <= 1'b0;
    ctrl(8'h20);
    chk({txd, txd_oe, tx_en}, 3'b011, "tx pin to serial");
    ctrl(8'h00);
    chk({txd, txd_oe, tx_en}, 3'b100, "tx pin to port");
    chk({rx_data, g_rxd, rx_en}, 3'b100, "rx pin to port");
    ctrl(8'h10);
    chk({rx_data, rx_en}, 2'b01, "rx pin to serial");
    ctrl(8'h20);
    ev(5'h10);
    chk(transmit_end_irq, 1'b0, "tei while disabled");
    ctrl(8'hA0);
    chk(transmit_end_irq, 1'b1, "tei while enabled");
    wb(1'b1, OFS_MASK, 32'h0000_0008);
    repeat (2) @(posedge clk);
    chk(irq, 1'b1, "irq unmasked");
    wb(1'b1, OFS_STATUS, 32'h0000_0008);
    repeat (2) @(posedge clk);
    chk({irq, transmit_end_irq}, 2'b00, "w1c clears");
    ctrl(8'h58);
    ev(5'h0B);
    wb(1'b0, OFS_STATUS, 32'h0000_0000);
    chk(q, 32'h0000_0000, "flags blocked");
    chk({receive_full_irq, receive_error_irq}, 2'b00, "requests held");
    ev(5'h0C);
    wb(1'b0, OFS_CTRL, 32'h0000_0000);
    chk(q, 32'h0000_0050, "mp enable cleared");
    chk({receive_full_irq, receive_error_irq}, 2'b10, "rx full raised");
    ev(5'h0A);
    chk({receive_full_irq, receive_error_irq}, 2'b11, "error raised");
    ctrl(8'h10);
    chk({receive_full_irq, receive_error_irq}, 2'b00, "both gated off");
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    wb(1'b0, OFS_STATUS, 32'h0000_0000);
    chk(q, 32'h0000_0000, "status after second reset");
    wb(1'b0, OFS_CTRL, 32'h0000_0000);
    chk(q, 32'h0000_0000, "ctrl after second reset");
    chk({irq, rx_data, rx_en}, 3'b010, "outputs after second reset");
    close_out();
  end
endmodule // test_serial_port_control
